// file: hdl/pfdc_pkg.sv
package pfdc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CFG_PREV_IDX = 8'h24;
  localparam logic [7:0] CFG_MUX_IDX  = 8'h25;
  localparam logic [7:0] CFG_LOCK_IDX = 8'h26;

  localparam int AXI_ADDR_W = 10;

  // Reset values
  localparam logic [7:0] CFG_PREV_RST = 8'h00;
  localparam logic [7:0] CFG_MUX_RST  = 8'h80;
  localparam logic [7:0] CFG_LOCK_RST = 8'h00;

  // Field positions of the multiplexer register
  localparam int MUX_STATUS_BIT = 7;
  localparam int MUX_P35_LSB    = 5;
  localparam int MUX_IRQ2_BIT   = 4;
  localparam int MUX_P34_BIT    = 3;
  localparam int MUX_PSAVE_BIT  = 2;
  localparam int MUX_P71_LSB    = 0;

  // Field positions of the disable/lock register
  localparam int LOCK_BIT     = 7;
  localparam int LOCK_RSV_BIT = 4;
  localparam int LOCK_SP1_BIT = 3;
  localparam int LOCK_SP2_BIT = 2;
  localparam int LOCK_PAR_BIT = 1;
  localparam int LOCK_FLOP_BIT = 0;

  // Field position of the preceding register
  localparam int PREV_P6_BIT = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    PFDC_P35_OFF       = 2'h0,
    PFDC_P35_LOW_PRN   = 2'h1,
    PFDC_P35_HIGH_PRN  = 2'h2,
    PFDC_P35_EXT_READY = 2'h3
  } pfdc_p35_t;

  typedef enum logic [1:0] {
    PFDC_P71_GL37     = 2'h0,
    PFDC_P71_DSEL1    = 2'h1,
    PFDC_P71_IR_SEL2  = 2'h2,
    PFDC_P71_EXT_IORD = 2'h3
  } pfdc_p71_t;

  typedef struct packed {
    logic                  pin6_clkrun;
    pfdc_p35_t             pin35_mode;
    logic                  pin34_ir_sel2;
    pfdc_p71_t             pin71_mode;
  } pfdc_pin_sel_t;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  awvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  arvalid;
    logic                  rready;
  } pfdc_axi_req_t;

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } pfdc_axi_rsp_t;

endpackage : pfdc_pkg

// file: hdl/pfdc_top.sv
// Notes on behaviour
// - Preceding bit 0 picks pin 6 function or CLKRUN
// - Bit 7 reads printer/floppy select in bits 6-5 modes 1-2, else 1; resets 1
// - Bits 6-5 pick multiplexer pin mode
// - Bit 4 routes management interrupt to IRQ2
// - Bit 3 picks data rate or infrared
// - Power save masks idle drive outputs only while bits 6-5 pick a printer mode and bit 7 reads 0
// - Bits 1-0 pick pin 71 function
// - Lock bit sticky; freezes bits 6-0
// - Bits 3-0 disable four functions
// - Activation also needs activate and global bits
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pfdc_top
(
  input  wire logic                    CLK_I,
  input  wire logic                    RST_I,
  input  wire logic                    CE_I,
  input  wire pfdc_pkg::pfdc_axi_req_t AXI_REQ_I,
  output var  pfdc_pkg::pfdc_axi_rsp_t AXI_RSP_O,
  input  wire logic                    PRN_FLOP_SEL_I,
  input  wire logic                    SMI_I,
  input  wire logic [3:0]              ACTIVATE_I,
  input  wire logic                    GLOBAL_EN_I,
  input  wire logic                    FLOP_IN_USE_I,
  input  wire logic                    PAR_IN_USE_I,
  output var  pfdc_pkg::pfdc_pin_sel_t PIN_SEL_O,
  output logic                         PORT_MUX_ACTIVE_O,
  output logic                         FLOP_MASK_O,
  output logic                         PAR_MASK_O,
  output logic                         IRQ2_O,
  output logic [3:0]                   FUNC_ACTIVE_O
);
  import pfdc_pkg::*;

  function automatic logic [AXI_ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  function automatic logic [1:0] decode(input logic [AXI_ADDR_W-1:0] addr);
    if (addr == byte_addr(CFG_PREV_IDX))
    begin
      decode = 2'd1;
    end
    else if (addr == byte_addr(CFG_MUX_IDX))
    begin
      decode = 2'd2;
    end
    else if (addr == byte_addr(CFG_LOCK_IDX))
    begin
      decode = 2'd3;
    end
    else
    begin
      decode = 2'd0;
    end
  endfunction : decode

  // Bus slave state
  logic                  aw_ok_q, aw_ok_d;
  logic                  w_ok_q, w_ok_d;
  logic [AXI_ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [7:0]            w_byte_q, w_byte_d;
  logic                  w_lane_q, w_lane_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  rvalid_q, rvalid_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [1:0]            rresp_q, rresp_d;
  logic                  awready, wready, arready, do_write;

  // Configuration registers
  logic [7:0] prev_q, prev_d;
  logic [6:0] mux_q, mux_d;
  logic [7:0] lock_q, lock_d;
  logic       sel_s1_q, sel_s2_q;
  logic       sel_status_q, sel_status_d;

  // Output registers
  pfdc_pin_sel_t pin_sel_d;
  logic          pmux_d, flop_mask_d, par_mask_d, irq2_d;
  logic [3:0]    func_d;

  assign awready  = CE_I & ~aw_ok_q & ~bvalid_q;
  assign wready   = CE_I & ~w_ok_q & ~bvalid_q;
  assign arready  = CE_I & ~rvalid_q;
  assign do_write = aw_ok_q & w_ok_q & ~bvalid_q;

  always_comb
  begin
    AXI_RSP_O         = '0;
    AXI_RSP_O.awready = awready;
    AXI_RSP_O.wready  = wready;
    AXI_RSP_O.bvalid  = bvalid_q;
    AXI_RSP_O.bresp   = bresp_q;
    AXI_RSP_O.arready = arready;
    AXI_RSP_O.rvalid  = rvalid_q;
    AXI_RSP_O.rdata   = rdata_q;
    AXI_RSP_O.rresp   = rresp_q;
  end

  always_comb
  begin
    aw_ok_d   = aw_ok_q;
    w_ok_d    = w_ok_q;
    aw_addr_d = aw_addr_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (AXI_REQ_I.awvalid && awready)
    begin
      aw_ok_d   = 1'b1;
      aw_addr_d = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && wready)
    begin
      w_ok_d   = 1'b1;
      w_byte_d = AXI_REQ_I.wdata[7:0];
      w_lane_d = AXI_REQ_I.wstrb[0];
    end
    if (do_write)
    begin
      aw_ok_d  = 1'b0;
      w_ok_d   = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (decode(aw_addr_q) == 2'd0) ? RESP_DECERR : RESP_OKAY;
    end
    else if (bvalid_q && AXI_REQ_I.bready)
    begin
      bvalid_d = 1'b0;
    end
    if (AXI_REQ_I.arvalid && arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (decode(AXI_REQ_I.araddr))
        2'd1:    rdata_d = {24'h000000, prev_q};
        2'd2:    rdata_d = {24'h000000, sel_status_q, mux_q};
        2'd3:    rdata_d = {24'h000000, lock_q};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
    else if (rvalid_q && AXI_REQ_I.rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      aw_ok_q   <= 1'b0;
      w_ok_q    <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      aw_ok_q   <= aw_ok_d;
      w_ok_q    <= w_ok_d;
      aw_addr_q <= aw_addr_d;
      w_byte_q  <= w_byte_d;
      w_lane_q  <= w_lane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Register writes; only byte lane 0 carries data
  always_comb
  begin
    prev_d = prev_q;
    mux_d  = mux_q;
    lock_d = lock_q;
    if (do_write && w_lane_q)
    begin
      unique case (decode(aw_addr_q))
        2'd1: prev_d[PREV_P6_BIT] = w_byte_q[PREV_P6_BIT];
        2'd2: mux_d = w_byte_q[6:0];
        2'd3:
        begin
          if (!lock_q[LOCK_BIT])
          begin
            lock_d = w_byte_q;
          end
          lock_d[LOCK_BIT]     = lock_q[LOCK_BIT] | w_byte_q[LOCK_BIT];
          lock_d[LOCK_RSV_BIT] = 1'b0;
        end
        default: prev_d = prev_q;
      endcase
    end
  end

  // Status follows the selected select-pin polarity
  always_comb
  begin
    unique case (pfdc_p35_t'(mux_q[MUX_P35_LSB +: 2]))
      PFDC_P35_LOW_PRN:  sel_status_d = sel_s2_q;
      PFDC_P35_HIGH_PRN: sel_status_d = ~sel_s2_q;
      default:           sel_status_d = 1'b1;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      prev_q       <= CFG_PREV_RST;
      mux_q        <= CFG_MUX_RST[6:0];
      lock_q       <= CFG_LOCK_RST;
      sel_s1_q     <= 1'b1;
      sel_s2_q     <= 1'b1;
      sel_status_q <= CFG_MUX_RST[MUX_STATUS_BIT];
    end
    else if (CE_I)
    begin
      prev_q       <= prev_d;
      mux_q        <= mux_d;
      lock_q       <= lock_d;
      sel_s1_q     <= PRN_FLOP_SEL_I;
      sel_s2_q     <= sel_s1_q;
      sel_status_q <= sel_status_d;
    end
  end

  // Outputs to the pin multiplexer and function blocks
  always_comb
  begin
    pin_sel_d.pin6_clkrun   = prev_q[PREV_P6_BIT];
    pin_sel_d.pin35_mode    = pfdc_p35_t'(mux_q[MUX_P35_LSB +: 2]);
    pin_sel_d.pin34_ir_sel2 = mux_q[MUX_P34_BIT];
    pin_sel_d.pin71_mode    = pfdc_p71_t'(mux_q[MUX_P71_LSB +: 2]);
    pmux_d      = (mux_q[MUX_P35_LSB +: 2] == PFDC_P35_LOW_PRN)
                | (mux_q[MUX_P35_LSB +: 2] == PFDC_P35_HIGH_PRN);
    flop_mask_d = mux_q[MUX_PSAVE_BIT] & pmux_d & ~sel_status_q & ~FLOP_IN_USE_I;
    par_mask_d  = mux_q[MUX_PSAVE_BIT] & pmux_d & ~sel_status_q & ~PAR_IN_USE_I;
    irq2_d      = mux_q[MUX_IRQ2_BIT] & SMI_I;
    func_d      = ACTIVATE_I & ~lock_q[3:0] & {4{GLOBAL_EN_I}};
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      PIN_SEL_O     <= '0;
      PORT_MUX_ACTIVE_O <= 1'b0;
      FLOP_MASK_O   <= 1'b0;
      PAR_MASK_O    <= 1'b0;
      IRQ2_O        <= 1'b0;
      FUNC_ACTIVE_O <= 4'h0;
    end
    else if (CE_I)
    begin
      PIN_SEL_O     <= pin_sel_d;
      PORT_MUX_ACTIVE_O <= pmux_d;
      FLOP_MASK_O   <= flop_mask_d;
      PAR_MASK_O    <= par_mask_d;
      IRQ2_O        <= irq2_d;
      FUNC_ACTIVE_O <= func_d;
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_lock_sticky: assert property (lock_q[LOCK_BIT] |=> lock_q[LOCK_BIT])
    else $error("lock bit cleared without reset");

  a_lock_freeze: assert property (lock_q[LOCK_BIT] |=> $stable(lock_q[6:0]))
    else $error("locked bits changed");

  a_rsv_zero: assert property (lock_q[LOCK_RSV_BIT] == 1'b0)
    else $error("reserved bit set");

  a_func_active: assert property (CE_I && !RST_I |=> FUNC_ACTIVE_O ==
      ($past(ACTIVATE_I) & ~$past(lock_q[3:0]) & {4{$past(GLOBAL_EN_I)}}))
    else $error("function activation wrong");

  a_irq2_route: assert property (CE_I && !mux_q[MUX_IRQ2_BIT] |=> !IRQ2_O)
    else $error("interrupt routed while disabled");

  a_sel_status: assert property (
      CE_I && !RST_I && mux_q[MUX_P35_LSB +: 2] == PFDC_P35_HIGH_PRN
      |=> sel_status_q == !$past(sel_s2_q))
    else $error("select status wrong polarity");

  a_mask_gate: assert property (
      CE_I && (!mux_q[MUX_PSAVE_BIT] || sel_status_q) |=> !FLOP_MASK_O && !PAR_MASK_O)
    else $error("mask active outside power save");

  a_pin6_sel: assert property (
      CE_I && !RST_I |=> PIN_SEL_O.pin6_clkrun == $past(prev_q[PREV_P6_BIT]))
    else $error("pin 6 select mismatch");

  a_pin71_sel: assert property (
      CE_I && !RST_I |=> PIN_SEL_O.pin71_mode == $past(mux_q[MUX_P71_LSB +: 2]))
    else $error("pin 71 select mismatch");

  a_ce_freeze: assert property (
      !CE_I && !RST_I |=> $stable(mux_q) && $stable(lock_q) && $stable(prev_q))
    else $error("state moved while clock enable low");

  a_bresp_hold: assert property (bvalid_q && !AXI_REQ_I.bready |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped");

endmodule : pfdc_top
`default_nettype wire

// file: verification/tb_pfdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pfdc_top;
  import pfdc_pkg::*;
  logic          clk, rst, ce, sel_pin, smi, glob, flop_use, par_use, pmux, flmask, pmask, irq2;
  logic          e_irq;
  logic [3:0]    act, fact, e_func;
  pfdc_axi_req_t req;
  pfdc_axi_rsp_t rsp;
  pfdc_pin_sel_t sel;
  logic [7:0]    m_prev, m_mux, m_lock, d;
  int            i, n_fail, samples_checked;

  pfdc_top i_pfdc_top
  (
    .CLK_I(clk), .RST_I(rst), .CE_I(ce), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
    .PRN_FLOP_SEL_I(sel_pin), .SMI_I(smi), .ACTIVATE_I(act), .GLOBAL_EN_I(glob),
    .FLOP_IN_USE_I(flop_use), .PAR_IN_USE_I(par_use), .PIN_SEL_O(sel),
    .PORT_MUX_ACTIVE_O(pmux), .FLOP_MASK_O(flmask), .PAR_MASK_O(pmask), .IRQ2_O(irq2),
    .FUNC_ACTIVE_O(fact)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task wr(input logic [9:0] a, input logic [7:0] v, input logic [1:0] er);
    int n;
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= {24'h0, v};
    req.wstrb   <= 4'hF;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
        break;
    end
    req.bready <= 1'b0;
    if (n == 50)
    begin
      n_fail++;
      stop_test();
    end
    chk("bresp", 32'(er), 32'(rsp.bresp));
  endtask : wr

  task rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        break;
    end
    req.rready <= 1'b0;
    if (n == 50)
    begin
      n_fail++;
      stop_test();
    end
    chk("rdata", {24'h0, e}, rsp.rdata);
    chk("rresp", 32'(er), 32'(rsp.rresp));
  endtask : rd

  task rin;
    @(posedge clk);
    sel_pin  <= 1'($urandom);
    smi      <= 1'($urandom);
    glob     <= 1'($urandom);
    flop_use <= 1'($urandom);
    par_use <= 1'($urandom);
    act     <= 4'($urandom);
  endtask : rin

  // Waits out the sync and output registers, then compares every output
  task outs;
    logic       st, pa;
    logic [1:0] md;
    repeat (5) @(posedge clk);
    md = m_mux[6:5];
    pa = (md == 2'h1) || (md == 2'h2);
    st = (md == 2'h1) ? sel_pin : ((md == 2'h2) ? ~sel_pin : 1'b1);
    chk("pin_sel", 32'({m_prev[0], md, m_mux[3], m_mux[1:0]}), 32'(sel));
    chk("port_mux", 32'(pa), 32'(pmux));
    chk("flop_mask", 32'(m_mux[2] & pa & ~st & ~flop_use), 32'(flmask));
    chk("par_mask", 32'(m_mux[2] & pa & ~st & ~par_use), 32'(pmask));
    chk("irq2", 32'(smi & m_mux[4]), 32'(irq2));
    chk("func", 32'(act & ~m_lock[3:0] & {4{glob}}), 32'(fact));
    rd(10'h094, {st, m_mux[6:0]}, RESP_OKAY);
  endtask : outs

  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    req = '0;
    rst = 1'b1;
    {sel_pin, smi, glob, flop_use, par_use, act} = '0;
    ce = 1'b1;
    {m_prev, m_mux, m_lock} = '0;
    void'($urandom(32'h90FFF1F4));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(10'h090, 8'h00, RESP_OKAY);
    rd(10'h098, 8'h00, RESP_OKAY);
    outs();
    rd(10'h09C, 8'h00, RESP_DECERR);
    wr(10'h09C, 8'hFF, RESP_DECERR);
    $display("Test reset and decode done");
    for (i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      d[6:5] = 2'(i);
      d[1:0] = 2'(i >> 2);
      wr(10'h094, d, RESP_OKAY);
      m_mux = {1'b0, d[6:0]};
      d = 8'($urandom);
      wr(10'h090, d, RESP_OKAY);
      m_prev = {7'h0, d[0]};
      rin();
      outs();
      rd(10'h090, m_prev, RESP_OKAY);
    end
    $display("Test pin functions done");
    for (i = 0; i < 6; i++)
    begin
      d = 8'($urandom) & 8'h7F;
      wr(10'h098, d, RESP_OKAY);
      m_lock = d & 8'h6F;
      rin();
      outs();
      rd(10'h098, m_lock, RESP_OKAY);
    end
    d = 8'($urandom) | 8'h80;
    wr(10'h098, d, RESP_OKAY);
    m_lock = d & 8'hEF;
    wr(10'h098, ~d & 8'h7F, RESP_OKAY);
    rd(10'h098, m_lock, RESP_OKAY);
    rin();
    outs();
    $display("Test lock done");
    // Outputs must hold the old inputs' result while the enable is low
    e_func = act & ~m_lock[3:0] & {4{glob}};
    e_irq  = smi & m_mux[4];
    @(posedge clk);
    ce <= 1'b0;
    rin();
    repeat (5) @(posedge clk);
    chk("awready", 32'h0, 32'(rsp.awready));
    chk("func_frozen", 32'(e_func), 32'(fact));
    chk("irq2_frozen", 32'(e_irq), 32'(irq2));
    ce <= 1'b1;
    outs();
    $display("Test clock enable done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    {m_prev, m_mux, m_lock} = '0;
    rd(10'h098, 8'h00, RESP_OKAY);
    outs();
    $display("Test second reset done");
    stop_test();
  end
endmodule : tb_pfdc_top
`default_nettype wire
